/* logic/cwsd_ctrl.sv */
/*
 * auto-shutdown and dead-band controller of a complementary waveform generator.
 * assumes the input source, comparator outputs and fault pin are synchronous to
 * mclk, and that the pad logic resolves each output from its enable.
 */
`timescale 1ns/1ps
module cwsd_ctrl (
    input wire logic mclk, // module clock, 20 MHz
    input wire logic rst_b, // synchronous reset, low active
    input wire logic [4:0] avs_address, // avalon byte address
    input wire logic avs_read, // avalon read
    input wire logic avs_write, // avalon write
    input wire logic [31:0] avs_writedata, // avalon write data
    input wire logic [3:0] avs_byteenable, // avalon byte enables
    output logic [31:0] avs_readdata, // avalon read data
    output logic avs_waitrequest, // avalon wait request
    input wire logic wave_in, // selected generator input source
    input wire logic cmp1_out, // comparator 1 output
    input wire logic cmp2_out, // comparator 2 output
    input wire logic fault_input_pin_b, // fault pin, low means fault
    output logic output_a, // output a level
    output logic output_a_oe, // output a drive enable
    output logic output_b, // output b level
    output logic output_b_oe, // output b drive enable
    output logic irq // level interrupt
);
    cwsd_reg_if regs ();

    logic [7:0] gen_q, gen_d, ovr_q, ovr_d, shd_cfg_q, shd_cfg_d, imsk_q, imsk_d;
    logic [5:0] dbr_q, dbr_d, dbf_q, dbf_d;
    logic flag_q, flag_d, in_prev_q, in_prev_d;
    cwsd_pkg::cwsd_shut_t st_q, st_d;
    logic [7:0] ist_q, ist_d;
    logic irq_q, irq_d;
    logic a_q, a_d, a_oe_q, a_oe_d, b_q, b_d, b_oe_q, b_oe_d;
    logic src_act, in_rise, shd_wr, db_a_in, db_b_in, db_a_out, db_b_out;
    logic gen_en, auto_en;
    logic [1:0] pin_a, pin_b;
    logic [7:0] clr_mask, events;

    cwsd_avmm_slave u_slave (
        .mclk(mclk),
        .rst_b(rst_b),
        .avs_address(avs_address),
        .avs_read(avs_read),
        .avs_write(avs_write),
        .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .regs(regs)
    );

    // ***********************************************************
    // configuration registers
    // ***********************************************************
    assign shd_wr = regs.wr_en && regs.addr == cwsd_pkg::OFF_SHD;
    assign gen_en = gen_q[cwsd_pkg::GEN_EN];
    assign auto_en = shd_cfg_q[cwsd_pkg::SHD_AUTO];

    // unimplemented bits are masked off at write time so they read as zero
    always_comb begin
        gen_d = gen_q;
        ovr_d = ovr_q;
        shd_cfg_d = shd_cfg_q;
        dbr_d = dbr_q;
        dbf_d = dbf_q;
        imsk_d = imsk_q;
        if (regs.wr_en) begin
            if (regs.addr == cwsd_pkg::OFF_GEN) begin
                gen_d = regs.wdata & cwsd_pkg::GEN_MASK;
            end else if (regs.addr == cwsd_pkg::OFF_OVR) begin
                ovr_d = regs.wdata & cwsd_pkg::OVR_MASK;
            end else if (regs.addr == cwsd_pkg::OFF_SHD) begin
                shd_cfg_d = regs.wdata & cwsd_pkg::SHD_CFG_MASK;
            end else if (regs.addr == cwsd_pkg::OFF_DBR) begin
                dbr_d = regs.wdata[5:0];
            end else if (regs.addr == cwsd_pkg::OFF_DBF) begin
                dbf_d = regs.wdata[5:0];
            end else if (regs.addr == cwsd_pkg::OFF_IMSK) begin
                imsk_d = regs.wdata & cwsd_pkg::IRQ_MASK;
            end
        end
    end

    // one reset only, so the dead-band counts take a plain known value
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            gen_q <= cwsd_pkg::REG_RST;
            ovr_q <= cwsd_pkg::REG_RST;
            shd_cfg_q <= cwsd_pkg::REG_RST;
            dbr_q <= cwsd_pkg::DB_RST;
            dbf_q <= cwsd_pkg::DB_RST;
            imsk_q <= cwsd_pkg::REG_RST;
        end else begin
            gen_q <= gen_d;
            ovr_q <= ovr_d;
            shd_cfg_q <= shd_cfg_d;
            dbr_q <= dbr_d;
            dbf_q <= dbf_d;
            imsk_q <= imsk_d;
        end
    end

    // read mux; unmapped addresses answer zero
    always_comb begin
        regs.rdata = 8'h00;
        if (regs.addr == cwsd_pkg::OFF_GEN) begin
            regs.rdata = gen_q;
        end else if (regs.addr == cwsd_pkg::OFF_OVR) begin
            regs.rdata = ovr_q;
        end else if (regs.addr == cwsd_pkg::OFF_SHD) begin
            regs.rdata = shd_cfg_q | {flag_q, 7'h00};
        end else if (regs.addr == cwsd_pkg::OFF_DBR) begin
            regs.rdata = {2'b00, dbr_q};
        end else if (regs.addr == cwsd_pkg::OFF_DBF) begin
            regs.rdata = {2'b00, dbf_q};
        end else if (regs.addr == cwsd_pkg::OFF_IST) begin
            regs.rdata = ist_q;
        end else if (regs.addr == cwsd_pkg::OFF_IMSK) begin
            regs.rdata = imsk_q;
        end
    end

    // ***********************************************************
    // shutdown flag and override state
    // ***********************************************************
    // level sensitive: a source held active keeps setting the flag each cycle
    assign src_act = (shd_cfg_q[cwsd_pkg::SHD_C2] && cmp2_out)
        || (shd_cfg_q[cwsd_pkg::SHD_C1] && cmp1_out)
        || (shd_cfg_q[cwsd_pkg::SHD_FLT] && !fault_input_pin_b);
    assign in_rise = wave_in && !in_prev_q;

    // a source beats any clear, so a software clear with a source up is lost
    always_comb begin
        flag_d = flag_q;
        if (src_act) begin
            flag_d = 1'b1;
        end else if (shd_wr) begin
            flag_d = regs.wdata[cwsd_pkg::SHD_FLAG];
        end else if (auto_en) begin
            flag_d = 1'b0;
        end
        in_prev_d = wave_in;
        st_d = st_q;
        case (st_q)
            cwsd_pkg::CWSD_RUN: begin
                if (flag_q) begin
                    st_d = cwsd_pkg::CWSD_SHUT;
                end
            end
            cwsd_pkg::CWSD_SHUT: begin
                // overrides stay until the first rising input once the flag is gone
                if (!flag_q && in_rise) begin
                    st_d = cwsd_pkg::CWSD_RUN;
                end
            end
            default: st_d = cwsd_pkg::CWSD_SHUT;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            flag_q <= 1'b0;
            in_prev_q <= 1'b0;
            st_q <= cwsd_pkg::CWSD_RUN;
        end else begin
            flag_q <= flag_d;
            in_prev_q <= in_prev_d;
            st_q <= st_d;
        end
    end

    // ***********************************************************
    // interrupt status and mask
    // ***********************************************************
    assign events = {6'h00, st_q == cwsd_pkg::CWSD_SHUT && st_d == cwsd_pkg::CWSD_RUN, flag_d && !flag_q};
    assign clr_mask = (regs.wr_en && regs.addr == cwsd_pkg::OFF_IST) ? regs.wdata & cwsd_pkg::IRQ_MASK : 8'h00;

    // a new event in the clearing cycle survives the clear
    always_comb begin
        ist_d = (ist_q & ~clr_mask) | events;
        irq_d = |(ist_d & imsk_d);
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            ist_q <= cwsd_pkg::REG_RST;
            irq_q <= 1'b0;
        end else begin
            ist_q <= ist_d;
            irq_q <= irq_d;
        end
    end

    // ***********************************************************
    // dead band and output pins
    // ***********************************************************
    // in shutdown both active levels drop, which gives the inactive level for code 00
    assign db_a_in = gen_en && st_q == cwsd_pkg::CWSD_RUN && wave_in;
    assign db_b_in = gen_en && st_q == cwsd_pkg::CWSD_RUN && !wave_in;

    cwsd_deadband u_db_rise (
        .mclk(mclk),
        .rst_b(rst_b),
        .in_lvl(db_a_in),
        .count(dbr_q),
        .out_q(db_a_out)
    );

    cwsd_deadband u_db_fall (
        .mclk(mclk),
        .rst_b(rst_b),
        .in_lvl(db_b_in),
        .count(dbf_q),
        .out_q(db_b_out)
    );

    // returns {enable, level}; override levels ignore polarity
    function automatic logic [1:0] pin_sel(input logic [1:0] code, input logic lvl, input logic oe,
                                           input logic shut);
        logic [1:0] res;
        res = {oe, lvl};
        if (shut) begin
            if (code == cwsd_pkg::OVR_HIGH) begin
                res = {oe, 1'b1};
            end else if (code == cwsd_pkg::OVR_LOW) begin
                res = {oe, 1'b0};
            end else if (code == cwsd_pkg::OVR_TRI) begin
                res = 2'b00;
            end
        end
        return res;
    endfunction

    assign pin_a = pin_sel(ovr_q[cwsd_pkg::OVR_A_LSB +: 2], db_a_out ^ gen_q[cwsd_pkg::GEN_POL_A],
                           gen_q[cwsd_pkg::GEN_OE_A], st_q == cwsd_pkg::CWSD_SHUT);
    assign pin_b = pin_sel(ovr_q[cwsd_pkg::OVR_B_LSB +: 2], db_b_out ^ gen_q[cwsd_pkg::GEN_POL_B],
                           gen_q[cwsd_pkg::GEN_OE_B], st_q == cwsd_pkg::CWSD_SHUT);

    // a disabled generator releases both pins
    always_comb begin
        a_oe_d = gen_en && pin_a[1];
        a_d = gen_en && pin_a[0];
        b_oe_d = gen_en && pin_b[1];
        b_d = gen_en && pin_b[0];
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            a_q <= 1'b0;
            a_oe_q <= 1'b0;
            b_q <= 1'b0;
            b_oe_q <= 1'b0;
        end else begin
            a_q <= a_d;
            a_oe_q <= a_oe_d;
            b_q <= b_d;
            b_oe_q <= b_oe_d;
        end
    end

    assign output_a = a_q;
    assign output_a_oe = a_oe_q;
    assign output_b = b_q;
    assign output_b_oe = b_oe_q;
    assign irq = irq_q;

    // ***********************************************************
    // checks
    // ***********************************************************
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_b);

    cmp2_shutdown_a: assert property (shd_cfg_q[cwsd_pkg::SHD_C2] && cmp2_out
        |=> flag_q ##1 st_q == cwsd_pkg::CWSD_SHUT)
        else $error("comparator 2 did not shut down");
    cmp1_shutdown_a: assert property (shd_cfg_q[cwsd_pkg::SHD_C1] && cmp1_out |=> flag_q)
        else $error("comparator 1 did not set the flag");
    fault_shutdown_a: assert property (shd_cfg_q[cwsd_pkg::SHD_FLT] && !fault_input_pin_b |=> flag_q)
        else $error("fault pin did not set the flag");
    flag_persist_a: assert property (src_act && shd_wr && !regs.wdata[cwsd_pkg::SHD_FLAG] |=> flag_q)
        else $error("flag cleared with a source active");
    sw_clear_a: assert property (shd_wr && !regs.wdata[cwsd_pkg::SHD_FLAG] && !src_act |=> !flag_q)
        else $error("software clear ignored");
    override_hold_a: assert property (st_q == cwsd_pkg::CWSD_SHUT && !(in_rise && !flag_q)
        |=> st_q == cwsd_pkg::CWSD_SHUT)
        else $error("override left without rising input");
    auto_clear_a: assert property (auto_en && flag_q && !src_act && !shd_wr |=> !flag_q)
        else $error("auto restart did not clear the flag");
    sw_set_a: assert property (shd_wr && regs.wdata[cwsd_pkg::SHD_FLAG]
        |=> flag_q ##1 st_q == cwsd_pkg::CWSD_SHUT)
        else $error("software set did not force shutdown");
    override_high_a: assert property (gen_en && st_q == cwsd_pkg::CWSD_SHUT
        && ovr_q[cwsd_pkg::OVR_A_LSB +: 2] == cwsd_pkg::OVR_HIGH |=> output_a)
        else $error("output a not driven high in shutdown");
    override_tri_a: assert property (st_q == cwsd_pkg::CWSD_SHUT
        && ovr_q[cwsd_pkg::OVR_B_LSB +: 2] == cwsd_pkg::OVR_TRI |=> !output_b_oe)
        else $error("output b driven while released");
endmodule

/* inc/cwsd_pkg.sv */
/*
 * constants and types of the shutdown and dead-band controller.
 * assumes nothing of its surroundings; the controller, the avalon slave and the bench refer here by scope.
 */
package cwsd_pkg;
    // ***********************************************************
    // register map, byte addresses on the avalon slave
    // ***********************************************************
    localparam logic [4:0] OFF_GEN = 5'h00; // generator_control
    localparam logic [4:0] OFF_OVR = 5'h04; // override_input_select
    localparam logic [4:0] OFF_SHD = 5'h08; // shutdown_control
    localparam logic [4:0] OFF_DBR = 5'h0C; // rising_deadband
    localparam logic [4:0] OFF_DBF = 5'h10; // falling_deadband
    localparam logic [4:0] OFF_IST = 5'h14; // interrupt status, write one to clear
    localparam logic [4:0] OFF_IMSK = 5'h18; // interrupt mask

    // ***********************************************************
    // field positions
    // ***********************************************************
    localparam int GEN_EN = 7;
    localparam int GEN_OE_B = 6;
    localparam int GEN_OE_A = 5;
    localparam int GEN_POL_B = 4;
    localparam int GEN_POL_A = 3;
    localparam int OVR_B_LSB = 6;
    localparam int OVR_A_LSB = 4;
    localparam int SHD_FLAG = 7;
    localparam int SHD_AUTO = 6;
    localparam int SHD_C2 = 3;
    localparam int SHD_C1 = 2;
    localparam int SHD_FLT = 1;
    localparam int IRQ_SHUT = 0;
    localparam int IRQ_RESUME = 1;
    localparam int DB_W = 6;

    // ***********************************************************
    // writable masks and reset values
    // ***********************************************************
    localparam logic [7:0] GEN_MASK = 8'hF9;
    localparam logic [7:0] OVR_MASK = 8'hF3;
    localparam logic [7:0] SHD_CFG_MASK = 8'h4E;
    localparam logic [7:0] IRQ_MASK = 8'h03;
    localparam logic [7:0] REG_RST = 8'h00;
    localparam logic [5:0] DB_RST = 6'h00;

    // override codes of a 2-bit shutdown level field
    localparam logic [1:0] OVR_HIGH = 2'b11;
    localparam logic [1:0] OVR_LOW = 2'b10;
    localparam logic [1:0] OVR_TRI = 2'b01;

    typedef enum logic [1:0] {CWSD_RUN = 2'b01, CWSD_SHUT = 2'b10} cwsd_shut_t;
    typedef enum logic [1:0] {CWSD_IDLE = 2'b01, CWSD_ACK = 2'b10} cwsd_bus_t;
endpackage

/* inc/cwsd_reg_if.sv */
/*
 * register access carrier between the avalon slave and the controller core.
 * assumes the slave presents one write strobe per accepted write.
 */
`timescale 1ns/1ps
interface cwsd_reg_if;
    logic wr_en;
    logic [4:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    modport slave (output wr_en, output addr, output wdata, input rdata);
    modport core (input wr_en, input addr, input wdata, output rdata);
endinterface

/* logic/cwsd_avmm_slave.sv */
/*
 * avalon-mm slave with waitrequest: one wait cycle, then one answer cycle.
 * assumes the master holds its request until it sees waitrequest low.
 */
`timescale 1ns/1ps
module cwsd_avmm_slave (
    input wire logic mclk, // module clock
    input wire logic rst_b, // synchronous reset, low active
    input wire logic [4:0] avs_address, // byte address
    input wire logic avs_read, // read request
    input wire logic avs_write, // write request
    input wire logic [31:0] avs_writedata, // write data
    input wire logic [3:0] avs_byteenable, // only lane 0 carries data
    output logic [31:0] avs_readdata, // registered read data
    output logic avs_waitrequest, // high until the answer cycle
    cwsd_reg_if.slave regs // register carrier
);
    cwsd_pkg::cwsd_bus_t st_q, st_d;
    logic [31:0] rdata_q, rdata_d;
    logic wait_q, wait_d;

    // ***********************************************************
    // access sequencing
    // ***********************************************************
    // the request is taken in the cycle after it rises, so reads are registered
    always_comb begin
        st_d = cwsd_pkg::CWSD_IDLE;
        rdata_d = rdata_q;
        if (st_q == cwsd_pkg::CWSD_IDLE && (avs_read || avs_write)) begin
            st_d = cwsd_pkg::CWSD_ACK;
            rdata_d = avs_read ? {24'h000000, regs.rdata} : 32'h00000000;
        end
        wait_d = (st_d != cwsd_pkg::CWSD_ACK);
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            st_q <= cwsd_pkg::CWSD_IDLE;
            rdata_q <= 32'h00000000;
            wait_q <= 1'b1;
        end else begin
            st_q <= st_d;
            rdata_q <= rdata_d;
            wait_q <= wait_d;
        end
    end

    // writes commit at the edge that ends the answer cycle
    assign regs.wr_en = (st_q == cwsd_pkg::CWSD_ACK) && avs_write && avs_byteenable[0];
    assign regs.addr = avs_address;
    assign regs.wdata = avs_writedata[7:0];
    assign avs_readdata = rdata_q;
    assign avs_waitrequest = wait_q;
endmodule

/* logic/cwsd_deadband.sv */
/*
 * delays the rising edge of one active level by a programmed count of clocks;
 * the falling edge passes at once. assumes count is stable while counting.
 */
`timescale 1ns/1ps
module cwsd_deadband (
    input wire logic mclk, // module clock
    input wire logic rst_b, // synchronous reset, low active
    input wire logic in_lvl, // requested active level
    input wire logic [5:0] count, // dead band in clocks
    output logic out_q // delayed active level
);
    logic [5:0] cnt_q, cnt_d;
    logic out_d;

    // ***********************************************************
    // dead-band counter
    // ***********************************************************
    // count zero releases on the next edge, so no delay is inserted
    always_comb begin
        out_d = in_lvl && (out_q || cnt_q >= count);
        cnt_d = 6'h00;
        if (in_lvl && !out_q && cnt_q < count) begin
            cnt_d = cnt_q + 6'h01;
        end else if (in_lvl) begin
            cnt_d = cnt_q;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            cnt_q <= 6'h00;
            out_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            out_q <= out_d;
        end
    end

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_b);

    db_hold_a: assert property (in_lvl && !out_q && cnt_q < count |=> !out_q)
        else $error("output left dead band early");
    db_release_a: assert property (in_lvl && cnt_q >= count |=> out_q)
        else $error("output not released after dead band");
endmodule

/* tb/cwsd_far_model.sv */
/*
 * far-side model: comparator outputs, fault pin and the selected input waveform.
 * assumes the bench requests each level after a rising edge of mclk.
 */
`timescale 1ns/1ps
module cwsd_far_model (
    input wire logic [2:0] src_act, // active request: 0 cmp2, 1 cmp1, 2 fault
    input wire logic wave_req, // requested waveform level
    output logic wave_in, // waveform to the generator
    output logic cmp1_out, // comparator 1, high active
    output logic cmp2_out, // comparator 2, high active
    output logic fault_input_pin_b // fault pin, low active
);
    // ***********************************************************
    // source levels
    // ***********************************************************
    // a fault is a low pin, so the request is inverted there only
    always_comb begin
        wave_in = wave_req;
        cmp2_out = src_act[0];
        cmp1_out = src_act[1];
        fault_input_pin_b = !src_act[2];
    end
endmodule

/* tb/cwg_shutdown_deadband_ctrl_bench.sv */
/*
 * self-checking bench of the shutdown and dead-band controller.
 * assumes the far-side model and a single 20 MHz clock.
 */
`timescale 1ns/1ps
module cwg_shutdown_deadband_ctrl_bench;
    logic mclk, rst_b, avs_read, avs_write, avs_waitrequest, wave_req, wave_in;
    logic cmp1_out, cmp2_out, fault_input_pin_b, output_a, output_a_oe, output_b, output_b_oe, irq;
    logic [4:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic [3:0] avs_byteenable;
    logic [2:0] src_act;
    logic [7:0] en;
    logic [5:0] nr, nf;
    logic [31:0] exp_q[$];
    int fails, compares, seed, k;

    cwsd_ctrl cwsd_ctrl_i (.mclk(mclk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .wave_in(wave_in),
        .cmp1_out(cmp1_out), .cmp2_out(cmp2_out), .fault_input_pin_b(fault_input_pin_b),
        .output_a(output_a), .output_a_oe(output_a_oe), .output_b(output_b), .output_b_oe(output_b_oe),
        .irq(irq));
    cwsd_far_model cwsd_far_model_i (.src_act(src_act), .wave_req(wave_req), .wave_in(wave_in),
        .cmp1_out(cmp1_out), .cmp2_out(cmp2_out), .fault_input_pin_b(fault_input_pin_b));

    // ***********************************************************
    // clock, compare and verdict
    // ***********************************************************
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic stop_test();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // one avalon access; for a read, d is the expected value noted for the monitor
    task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
        int n;
        if (!wr) repeat (3) @(posedge mclk); // lets status settle before sampling it
        @(posedge mclk);
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        if (wr) avs_write <= 1'b1;
        else begin
            avs_read <= 1'b1;
            exp_q.push_back({24'h0, d});
        end
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (n >= 50) begin
            fails++;
            stop_test();
        end
    endtask

    // counts edges until the chosen pin goes high, bounded
    task automatic wait_pin(input logic b, input logic [31:0] e);
        int n;
        n = 0;
        do begin
            @(posedge mclk);
            #1;
            n++;
        end while ((b ? output_b : output_a) !== 1'b1 && n < 100);
        check(n, e);
    endtask

    // read data monitor: oldest note against each answered read
    always @(posedge mclk) begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
            if (exp_q.size() == 0) fails++;
            else check(avs_readdata, exp_q.pop_front());
        end
    end

    // ***********************************************************
    // scenarios
    // ***********************************************************
    initial begin
        seed = 84797;
        fails = 0;
        compares = 0;
        rst_b = 1'b0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 5'h00;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hF;
        wave_req = 1'b1;
        src_act = 3'h0;
        repeat (6) @(posedge mclk);
        rst_b <= 1'b1;
        bus(1'b0, cwsd_pkg::OFF_SHD, 8'h00);
        bus(1'b0, 5'h1C, 8'h00);
        // dead band: random rising count with zero falling, then the reverse
        for (k = 0; k < 2; k++) begin
            nr = (k == 0) ? 6'($random(seed)) : 6'h00;
            nf = (k == 0) ? 6'h00 : 6'($random(seed));
            bus(1'b1, cwsd_pkg::OFF_DBR, {2'h0, nr});
            bus(1'b1, cwsd_pkg::OFF_DBF, {2'h0, nf});
            bus(1'b0, cwsd_pkg::OFF_DBR, {2'h0, nr});
            bus(1'b1, cwsd_pkg::OFF_GEN, 8'hE0);
            repeat (70) @(posedge mclk);
            wave_req <= 1'b0;
            wait_pin(1'b1, 32'(nf) + 32'd2);
            @(posedge mclk);
            wave_req <= 1'b1;
            wait_pin(1'b0, 32'(nr) + 32'd2);
        end
        bus(1'b1, cwsd_pkg::OFF_DBF, 8'hFF);
        bus(1'b0, cwsd_pkg::OFF_DBF, 8'h3F);
        bus(1'b1, cwsd_pkg::OFF_OVR, 8'hE0);
        bus(1'b1, cwsd_pkg::OFF_IMSK, 8'h01);
        // each source: ignored when disabled, latched, clear refused while active
        for (k = 0; k < 3; k++) begin
            en = 8'h08 >> k;
            src_act <= 3'b001 << k;
            bus(1'b1, cwsd_pkg::OFF_SHD, 8'h00);
            bus(1'b0, cwsd_pkg::OFF_SHD, 8'h00);
            bus(1'b1, cwsd_pkg::OFF_SHD, en);
            bus(1'b0, cwsd_pkg::OFF_SHD, en | 8'h80);
            bus(1'b1, cwsd_pkg::OFF_SHD, en);
            bus(1'b0, cwsd_pkg::OFF_SHD, en | 8'h80);
            check({31'h0, output_a}, 32'h0);
            check({31'h0, output_b}, 32'h1);
            src_act <= 3'h0;
            bus(1'b1, cwsd_pkg::OFF_SHD, en);
            bus(1'b0, cwsd_pkg::OFF_SHD, en);
        end
        bus(1'b0, cwsd_pkg::OFF_IST, 8'h01);
        check({31'h0, irq}, 32'h1);
        bus(1'b1, cwsd_pkg::OFF_IST, 8'h01);
        bus(1'b0, cwsd_pkg::OFF_IST, 8'h00);
        check({31'h0, irq}, 32'h0);
        // automatic restart clears the flag once the source drops
        bus(1'b1, cwsd_pkg::OFF_SHD, 8'h44);
        src_act <= 3'b010;
        bus(1'b0, cwsd_pkg::OFF_SHD, 8'hC4);
        src_act <= 3'h0;
        bus(1'b0, cwsd_pkg::OFF_SHD, 8'h44);
        bus(1'b1, cwsd_pkg::OFF_SHD, 8'h80);
        bus(1'b0, cwsd_pkg::OFF_SHD, 8'h80);
        // a high and a released override, then a software restart on a rising input
        bus(1'b1, cwsd_pkg::OFF_OVR, 8'h70);
        bus(1'b0, cwsd_pkg::OFF_OVR, 8'h70);
        check({31'h0, output_a}, 32'h1);
        check({31'h0, output_b_oe}, 32'h0);
        bus(1'b1, cwsd_pkg::OFF_SHD, 8'h00);
        wave_req <= 1'b0;
        repeat (2) @(posedge mclk);
        check({31'h0, output_b_oe}, 32'h0);
        wave_req <= 1'b1;
        bus(1'b0, cwsd_pkg::OFF_IST, 8'h03);
        check({31'h0, output_b_oe}, 32'h1);
        stop_test();
    end
endmodule
